/* rtl/asr_consts.svh */
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// Register offsets
`define ASR_A_BAUDCTL 3'h0
`define ASR_A_RXSTAT 3'h1
`define ASR_A_RXDATA 3'h2
`define ASR_A_DIVLO 3'h3
`define ASR_A_DIVHI 3'h4
`define ASR_A_TXSTAT 3'h5
`define ASR_A_INTCTL 3'h6
`define ASR_A_INTEN 3'h7
// Receive status/control fields
`define ASR_B_EN 7
`define ASR_B_NINE 6
`define ASR_B_SINGLE_RECEIVE_ENABLE 5
`define ASR_B_CONTINUOUS_RECEIVE_ENABLE 4
`define ASR_B_ADDRESS_DETECT_ENABLE 3
// Baud control fields
`define ASR_B_POL 5
`define ASR_B_TXPOL 4
`define ASR_B_WIDE 3
// Transmit status/control fields
`define ASR_B_SYNC 4
`define ASR_B_HIGH_SPEED_BAUD_SELECT 2
`define ASR_B_TRMT 1
// Interrupt fields
`define ASR_B_GIE 7
`define ASR_B_PEIE 6
`define ASR_B_RCIE 1
// Reset values
`define ASR_RST8 8'h00
`define ASR_RST16 16'h0000
// Sample timing in ticks: sixteenth-bit, quarter-bit when fast
`define ASR_LAST_FULL 4'hf
`define ASR_LAST_FAST 4'h3
`define ASR_HALF_FULL 4'h7
`define ASR_HALF_FAST 4'h1
`define ASR_PRE_SLOW 2'h3
`endif

/* rtl/asr_pkg.sv */
package asr_pkg;
    // Receiver states, Gray along the path
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA = 2'b11,
        ASR_STOP = 2'b10
    } asr_state_t;
    // Whole block state
    typedef struct packed {
        asr_state_t st;
        logic port_enable;
        logic nine;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic overrun_error;
        logic pol;
        logic txpol;
        logic wide;
        logic [7:0] txr;
        logic [7:0] divlo;
        logic [7:0] divhi;
        logic [15:0] brg;
        logic [1:0] pre;
        logic [3:0] cnt;
        logic [3:0] idx;
        logic [2:0] hist;
        logic prev;
        logic [8:0] receive_shift_register;
        logic [1:0][9:0] mem;
        logic head;
        logic [1:0] count;
        logic gie;
        logic peie;
        logic rcie;
        logic rxf;
        logic irq;
        logic [7:0] rdata;
    } asr_regs_t;
endpackage : asr_pkg

/* rtl/asr_receiver.sv */
`timescale 1ns/1ps
`include "asr_consts.svh"

// How it works
// [RL1] Bit timing from divisor, speed, width bits
// [RL2] Works only when enabled and asynchronous
// [RL3] Software sets both pins as inputs
// [RL4] Nine-bit select shifts nine data bits
// [RL5] Polarity bit inverts incoming line
// [RL6] Reception starts only with continuous enable
// [RL7] Flag on buffer load; interrupt needs enable
// [RL8] Interrupt also needs global, peripheral enables
// [RL9] Status shows errors and ninth bit
// [RL10] Data read returns head low byte
// [RL11] Clearing continuous enable clears overrun
// [RL12] Address mode keeps only ninth-bit characters; code filters only when nine-bit select is set
// [RL13] Ninth bit reads set in address mode
// [RL14] Software compares addresses itself
// [RL15] Address mode off admits all characters
// [RL16] Status bits: enable down to ninth
// [RL17] Unimplemented bits read zero; code reads spare transmit status bits back as written
// [RL18] Sixteen samples per bit, four in fast mode, majority vote
// [RL19] Half-bit start recheck, silent abort
// [RL20] Low stop sample marks framing error
// [RL21] Two-deep buffer; third sets overrun, blocks
// [RL22] Port disabled holds receiver in reset
module asr_receiver
    import asr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [2:0] i_address,
    input wire logic [7:0] i_write_data,
    input wire logic i_write_strobe,
    input wire logic i_read_strobe,
    input wire logic i_receive_pin,
    output logic [7:0] o_read_data,
    output logic o_receive_flag,
    output logic o_interrupt
);

    // ---------------------------------------------
    // State and helpers
    // ---------------------------------------------
    asr_regs_t q; // Registered state
    asr_regs_t d; // Next state
    logic rx; // Line after polarity
    logic tick; // Sample tick
    logic fast; // Four samples per bit
    logic [3:0] last; // Last tick of a bit
    logic [3:0] half; // Half-bit tick
    logic [15:0] top; // Divisor in use
    logic maj; // Majority of three
    logic done; // Bit decision moment
    logic [8:0] chr; // Assembled character
    logic pop; // Buffer read
    logic wr; // Register write
    logic rd; // Register read
    logic run; // Receiver allowed

    // Majority of three samples
    function automatic logic asr_maj(input logic [2:0] s);
        asr_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : asr_maj

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb
    begin
        d = q;
        wr = i_write_strobe;
        rd = i_read_strobe;
        // [RL5] Optional line inversion
        rx = i_receive_pin ^ q.pol;
        // [RL1] Divisor width selection
        top = q.wide ? {q.divhi, q.divlo} : {8'h00, q.divlo};
        fast = q.wide & q.txr[`ASR_B_HIGH_SPEED_BAUD_SELECT];
        last = fast ? `ASR_LAST_FAST : `ASR_LAST_FULL;
        half = fast ? `ASR_HALF_FAST : `ASR_HALF_FULL;
        maj = asr_maj({q.hist[1:0], rx}); // Vote ends on the newest sample
        // [RL2] Enabled, continuous, asynchronous
        run = q.port_enable & q.continuous_receive_enable & ~q.txr[`ASR_B_SYNC] & ~q.overrun_error;
        pop = rd && (i_address == `ASR_A_RXDATA) && (q.count != 2'h0);
        chr = q.nine ? q.receive_shift_register : {1'b0, q.receive_shift_register[8:1]};
        tick = 1'b0;
        done = 1'b0;
        // [RL1] Free-running baud timer
        if (q.brg == top)
        begin
            d.brg = `ASR_RST16;
            // Slow mode needs four timer wraps per tick
            if (!q.wide && !q.txr[`ASR_B_HIGH_SPEED_BAUD_SELECT])
            begin
                d.pre = q.pre + 2'h1;
                tick = (q.pre == `ASR_PRE_SLOW);
            end
            else
            begin
                tick = 1'b1;
            end
        end
        else
        begin
            d.brg = q.brg + 16'h0001;
        end
        // [RL18] Sample history for the vote
        if (tick)
        begin
            d.hist = {q.hist[1:0], rx};
        end
        d.prev = rx;
        done = tick && (q.cnt == last);
        // Receiver sequence
        case (q.st)
            ASR_IDLE:
            begin
                // [RL6] Edge search only when running
                if (run && q.prev && !rx)
                begin
                    d.st = ASR_START;
                    d.cnt = 4'h0;
                end
            end
            ASR_START:
            begin
                if (tick)
                begin
                    d.cnt = q.cnt + 4'h1;
                    // [RL19] Recheck start at half bit
                    if (q.cnt == half)
                    begin
                        d.cnt = 4'h0;
                        d.idx = 4'h0;
                        d.st = rx ? ASR_IDLE : ASR_DATA;
                    end
                end
            end
            ASR_DATA:
            begin
                if (tick)
                begin
                    d.cnt = q.cnt + 4'h1;
                end
                // [RL18] Decide bit by majority
                if (done)
                begin
                    d.cnt = 4'h0;
                    d.receive_shift_register = {maj, q.receive_shift_register[8:1]};
                    d.idx = q.idx + 4'h1;
                    // [RL4] Eight or nine data bits
                    if (q.idx == (q.nine ? 4'h8 : 4'h7))
                    begin
                        d.st = ASR_STOP;
                    end
                end
            end
            ASR_STOP:
            begin
                if (tick)
                begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (done)
                begin
                    d.st = ASR_IDLE;
                    d.cnt = 4'h0;
                    // [RL12] Drop non-address characters in nine-bit mode
                    // [RL15] Otherwise every character passes
                    if (!(q.address_detect_enable && q.nine && !chr[8]))
                    begin
                        // [RL21] Third character overruns
                        if (q.count == 2'h2)
                        begin
                            d.overrun_error = 1'b1;
                        end
                        else
                        begin
                            // [RL20] Stop sample kept with character
                            d.mem[q.head ^ q.count[0]] = {~maj, chr};
                            d.count = q.count + 2'h1;
                        end
                    end
                end
            end
            default:
            begin
                d.st = ASR_IDLE;
            end
        endcase
        // Head leaves on a data read
        if (pop)
        begin
            d.head = ~q.head;
            d.count = d.count - 2'h1;
        end
        // Register writes
        if (wr)
        begin
            if (i_address == `ASR_A_BAUDCTL)
            begin
                d.pol = i_write_data[`ASR_B_POL];
                d.txpol = i_write_data[`ASR_B_TXPOL];
                d.wide = i_write_data[`ASR_B_WIDE];
            end
            else if (i_address == `ASR_A_RXSTAT)
            begin
                d.port_enable = i_write_data[`ASR_B_EN];
                d.nine = i_write_data[`ASR_B_NINE];
                d.single_receive_enable = i_write_data[`ASR_B_SINGLE_RECEIVE_ENABLE];
                d.continuous_receive_enable = i_write_data[`ASR_B_CONTINUOUS_RECEIVE_ENABLE];
                d.address_detect_enable = i_write_data[`ASR_B_ADDRESS_DETECT_ENABLE];
                // [RL11] Overrun cleared, new set wins
                if (!i_write_data[`ASR_B_CONTINUOUS_RECEIVE_ENABLE])
                begin
                    d.overrun_error = d.overrun_error & ~q.overrun_error;
                end
            end
            else if (i_address == `ASR_A_DIVLO)
            begin
                // [RL1] New divisor restarts timer
                d.divlo = i_write_data;
                d.brg = `ASR_RST16;
                d.pre = 2'h0;
            end
            else if (i_address == `ASR_A_DIVHI)
            begin
                d.divhi = i_write_data;
                d.brg = `ASR_RST16;
                d.pre = 2'h0;
            end
            else if (i_address == `ASR_A_TXSTAT)
            begin
                d.txr = i_write_data;
            end
            else if (i_address == `ASR_A_INTCTL)
            begin
                d.gie = i_write_data[`ASR_B_GIE];
                d.peie = i_write_data[`ASR_B_PEIE];
            end
            else if (i_address == `ASR_A_INTEN)
            begin
                d.rcie = i_write_data[`ASR_B_RCIE];
            end
        end
        // Register reads, one cycle later
        d.rdata = `ASR_RST8;
        if (rd)
        begin
            // [RL17] Spare bits read zero, except in the transmit status register, which reads back as written
            if (i_address == `ASR_A_BAUDCTL)
            begin
                d.rdata = {1'b0, q.st == ASR_IDLE, q.pol, q.txpol, q.wide, 3'h0};
            end
            else if (i_address == `ASR_A_RXSTAT)
            begin
                // [RL16] Field order of status register
                // [RL9] Errors and ninth bit of head
                // [RL13] Ninth bit forced in address mode
                d.rdata = {q.port_enable, q.nine, q.single_receive_enable, q.continuous_receive_enable, q.address_detect_enable,
                           (q.count != 2'h0) & q.mem[q.head][9], q.overrun_error,
                           ((q.count != 2'h0) & q.mem[q.head][8]) | q.address_detect_enable};
            end
            else if (i_address == `ASR_A_RXDATA)
            begin
                // [RL10] Low byte of head character
                d.rdata = (q.count != 2'h0) ? q.mem[q.head][7:0] : `ASR_RST8;
            end
            else if (i_address == `ASR_A_DIVLO)
            begin
                d.rdata = q.divlo;
            end
            else if (i_address == `ASR_A_DIVHI)
            begin
                d.rdata = q.divhi;
            end
            else if (i_address == `ASR_A_TXSTAT)
            begin
                // Transmit shifter always empty here
                d.rdata = q.txr | 8'h02;
            end
            else if (i_address == `ASR_A_INTCTL)
            begin
                d.rdata = {q.gie, q.peie, 6'h00};
            end
            else
            begin
                d.rdata = {6'h00, q.rcie, q.count != 2'h0};
            end
        end
        // [RL22] Disabled port held in reset
        if (!d.port_enable)
        begin
            d.st = ASR_IDLE;
            d.cnt = 4'h0;
            d.idx = 4'h0;
            d.count = 2'h0;
            d.head = 1'b0;
            d.overrun_error = 1'b0;
        end
        // [RL7] Flag while an unread character waits
        d.rxf = (d.count != 2'h0);
        // [RL8] Interrupt needs all three enables
        d.irq = d.rxf & d.rcie & d.gie & d.peie;
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            q <= '0;
            q.prev <= 1'b1;
            q.hist <= 3'h7;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign o_read_data = q.rdata;
    assign o_receive_flag = q.rxf;
    assign o_interrupt = q.irq;

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    property p_pop;
        pop && q.st != ASR_STOP |=> q.count == $past(q.count) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not pop buffer"); // [RL10]

    property p_off;
        !q.port_enable |-> q.count == 2'h0 && q.st == ASR_IDLE && !q.overrun_error;
    endproperty
    a_off: assert property (p_off) else $error("disabled port not in reset"); // [RL22]

    property p_oclr;
        wr && i_address == `ASR_A_RXSTAT && !i_write_data[`ASR_B_CONTINUOUS_RECEIVE_ENABLE] && q.st != ASR_STOP |=> !q.overrun_error;
    endproperty
    a_oclr: assert property (p_oclr) else $error("overrun not cleared"); // [RL11]

    property p_zero;
        rd && i_address == `ASR_A_BAUDCTL |=> o_read_data[2] == 1'b0 && o_read_data[7] == 1'b0;
    endproperty
    a_zero: assert property (p_zero) else $error("spare bit read nonzero"); // [RL17]

    property p_irq;
        o_interrupt |-> o_receive_flag && q.gie && q.peie && q.rcie;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enables"); // [RL8]

    property p_flag;
        done && q.st == ASR_STOP && !q.address_detect_enable && q.count != 2'h2 && q.port_enable ##1 q.port_enable |-> o_receive_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set on load"); // [RL7]

    property p_block;
        q.overrun_error && q.st == ASR_IDLE |=> q.st == ASR_IDLE;
    endproperty
    a_block: assert property (p_block) else $error("reception during overrun"); // [RL21]

    property p_addr;
        done && q.st == ASR_STOP && q.address_detect_enable && q.nine && !chr[8] && !pop && d.port_enable |=> q.count == $past(q.count);
    endproperty
    a_addr: assert property (p_addr) else $error("data character buffered"); // [RL12]

    property p_abort;
        q.st == ASR_START && tick && q.cnt == half && rx && d.port_enable |=> q.st == ASR_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("false start not aborted"); // [RL19]

    property p_ninth;
        rd && i_address == `ASR_A_RXSTAT && q.address_detect_enable |=> o_read_data[0];
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit clear in address mode"); // [RL13]

endmodule : asr_receiver

/* test/asr_serial_tx_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Remote transmitter driving the line
// ----------------------------------------
module asr_serial_tx_model
(
    input wire logic i_clock,
    output logic o_line
);
    // Line level between frames
    logic idle_lvl = 1'b1;

    initial o_line = 1'b1;

    // Select the idle level of the line
    task automatic set_idle(input logic lvl);
        idle_lvl = lvl;
        @(posedge i_clock);
        o_line <= lvl;
    endtask : set_idle

    // One bit held for per clocks
    task automatic put_bit(input logic b, input int per);
        @(posedge i_clock);
        o_line <= b ^ ~idle_lvl;
        repeat (per - 1) @(posedge i_clock);
    endtask : put_bit

    // Only this model drives the pin
    task automatic send(input logic [8:0] d, input logic nine, input logic stop, input int per);
        put_bit(1'b0, per);
        for (int i = 0; i < 9; i++)
            if (i < 8 || nine) put_bit(d[i], per);
        put_bit(stop, per);
        put_bit(1'b1, 2);
    endtask : send

    // Short low pulse, no frame behind it
    task automatic glitch(input int n);
        put_bit(1'b0, n);
        put_bit(1'b1, 1);
    endtask : glitch
endmodule : asr_serial_tx_model

/* test/asr_receiver_tb_top.sv */
`timescale 1ns/1ps
`include "asr_consts.svh"

module asr_receiver_tb_top;
    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    typedef struct packed {
        logic [8:0] dat;
        logic [7:0] rx;
        logic [7:0] bc;
        logic [7:0] tx;
        logic [7:0] per;
        logic stop;
        logic keep;
        logic [2:0] st;
    } asr_row_t;

    logic clock;
    logic reset_n;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic pin;
    logic [7:0] rdata;
    logic flag;
    logic irq;
    int error_cnt = 0;
    int num_checks = 0;

    // Frame, config, bit period, expected status
    asr_row_t rows [11] = '{
        '{9'h0a5, 8'h90, 8'h08, 8'h04, 8'h08, 1'b1, 1'b1, 3'h0},
        '{9'h03c, 8'h90, 8'h28, 8'h04, 8'h08, 1'b1, 1'b1, 3'h0},
        '{9'h15a, 8'hd0, 8'h08, 8'h04, 8'h08, 1'b1, 1'b1, 3'h1},
        '{9'h081, 8'hd0, 8'h00, 8'h04, 8'h20, 1'b1, 1'b1, 3'h0},
        '{9'h077, 8'h90, 8'h08, 8'h04, 8'h08, 1'b0, 1'b1, 3'h4},
        '{9'h042, 8'hd8, 8'h08, 8'h04, 8'h08, 1'b1, 1'b0, 3'h0},
        '{9'h142, 8'hd8, 8'h08, 8'h04, 8'h08, 1'b1, 1'b1, 3'h1},
        '{9'h0c3, 8'h90, 8'h08, 8'h00, 8'h20, 1'b1, 1'b1, 3'h0},
        '{9'h055, 8'h90, 8'h00, 8'h00, 8'h80, 1'b1, 1'b1, 3'h0},
        '{9'h0aa, 8'h90, 8'h08, 8'h14, 8'h08, 1'b1, 1'b0, 3'h0},
        '{9'h0aa, 8'h80, 8'h08, 8'h04, 8'h08, 1'b1, 1'b0, 3'h0}
    };
    // Reset values, write-back values, compare masks
    logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    logic [7:0] wr_exp [8] = '{8'h38, 8'hf8, 8'h00, 8'hff, 8'hff, 8'h16, 8'hc0, 8'h02};
    logic [7:0] msk [8] = '{8'hbf, 8'hfe, 8'hff, 8'hff, 8'hff, 8'h16, 8'hc0, 8'hff};

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    asr_receiver i_asr_receiver (
        .i_clock(clock),
        .i_reset_n(reset_n),
        .i_address(addr),
        .i_write_data(wdata),
        .i_write_strobe(wr_s),
        .i_read_strobe(rd_s),
        .i_receive_pin(pin),
        .o_read_data(rdata),
        .o_receive_flag(flag),
        .o_interrupt(irq)
    );

    asr_serial_tx_model i_asr_serial_tx_model (
        .i_clock(clock),
        .o_line(pin)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Verdict and end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Compare seen against expected
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Let n edges pass, then settle
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // One-cycle register write
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
    endtask : wr

    // Read, data taken the cycle after the strobe
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask : rdc

    // Port set up from scratch
    task automatic cfg(input logic [7:0] rx, input logic [7:0] bc, input logic [7:0] tx);
        wr(`ASR_A_RXSTAT, 8'h00);
        i_asr_serial_tx_model.set_idle(~bc[`ASR_B_POL]);
        wr(`ASR_A_BAUDCTL, bc);
        wr(`ASR_A_TXSTAT, tx);
        wr(`ASR_A_DIVLO, 8'h01);
        wr(`ASR_A_INTCTL, 8'hc0);
        wr(`ASR_A_INTEN, 8'h02);
        wr(`ASR_A_RXSTAT, rx);
    endtask : cfg

    // ----------------------------------------
    // Clock, reset, watchdog
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cut a hang short
    initial
    begin
        repeat (80000) @(posedge clock);
        error_cnt++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        reset_n = 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        // Ordinary frames from the table
        foreach (rows[n])
        begin
            cfg(rows[n].rx, rows[n].bc, rows[n].tx);
            i_asr_serial_tx_model.send(rows[n].dat, rows[n].rx[6], rows[n].stop, int'(rows[n].per));
            settle(8);
            chk({7'h0, flag}, {7'h0, rows[n].keep});
            chk({7'h0, irq}, {7'h0, rows[n].keep});
            rdc(`ASR_A_RXSTAT, {rows[n].rx[7:3], rows[n].st}, {5'h1f, {3{rows[n].keep}}});
            rdc(`ASR_A_RXDATA, rows[n].keep ? rows[n].dat[7:0] : 8'h00, 8'hff);
            settle(2);
            chk({7'h0, flag}, 8'h00);
        end
        // Three frames into two places, interrupt masked
        cfg(8'h90, 8'h08, 8'h04);
        wr(`ASR_A_INTCTL, 8'h40);
        for (int k = 0; k < 3; k++)
            i_asr_serial_tx_model.send(9'h0a1 + 9'(k), 1'b0, 1'b1, 8);
        settle(8);
        chk({7'h0, irq}, 8'h00);
        rdc(`ASR_A_RXSTAT, 8'h92, 8'hff);
        rdc(`ASR_A_RXDATA, 8'ha1, 8'hff);
        rdc(`ASR_A_RXDATA, 8'ha2, 8'hff);
        i_asr_serial_tx_model.send(9'h05e, 1'b0, 1'b1, 8);
        settle(8);
        chk({7'h0, flag}, 8'h00);
        wr(`ASR_A_RXSTAT, 8'h80);
        rdc(`ASR_A_RXSTAT, 8'h80, 8'hff);
        wr(`ASR_A_RXSTAT, 8'h90);
        wr(`ASR_A_INTCTL, 8'hc0);
        // False start, then a real frame
        i_asr_serial_tx_model.glitch(2);
        settle(10);
        i_asr_serial_tx_model.send(9'h069, 1'b0, 1'b1, 8);
        settle(8);
        chk({7'h0, irq}, 8'h01);
        rdc(`ASR_A_RXDATA, 8'h69, 8'hff);
        settle(2);
        chk({7'h0, flag}, 8'h00);
        // Port disable drops frame and error
        i_asr_serial_tx_model.send(9'h033, 1'b0, 1'b0, 8);
        settle(8);
        wr(`ASR_A_RXSTAT, 8'h00);
        settle(2);
        chk({7'h0, flag}, 8'h00);
        rdc(`ASR_A_RXSTAT, 8'h00, 8'hff);
        // Address matched by software, then data admitted
        cfg(8'hd8, 8'h08, 8'h04);
        i_asr_serial_tx_model.send(9'h142, 1'b1, 1'b1, 8);
        settle(8);
        rdc(`ASR_A_RXDATA, 8'h42, 8'hff);
        wr(`ASR_A_RXSTAT, 8'hd0);
        i_asr_serial_tx_model.send(9'h033, 1'b1, 1'b1, 8);
        settle(8);
        chk({7'h0, flag}, 8'h01);
        rdc(`ASR_A_RXSTAT, 8'hd0, 8'hff);
        rdc(`ASR_A_RXDATA, 8'h33, 8'hff);
        // Second reset, then every register
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++)
            rdc(3'(a), rst_exp[a], msk[a]);
        for (int a = 7; a >= 0; a--)
            wr(3'(a), 8'hff);
        for (int a = 0; a < 8; a++)
            rdc(3'(a), wr_exp[a], msk[a]);
        report_and_stop();
    end
endmodule : asr_receiver_tb_top
